// ---- hdl/error_capture_regs.vh ----
// register map, field positions, codes and reset values of the error capture
`ifndef ERROR_CAPTURE_REGS_VH
`define ERROR_CAPTURE_REGS_VH

// byte addresses of the word registers
`define CYCLE_STATE_STATUS_ADDR 12'h000
`define PROCESSOR_CHECK_STATUS_ADDR 12'h004
`define STORAGE_CHECK_STATUS_ADDR 12'h008
`define FAILING_REAL_ADDRESS_ADDR 12'h00c
`define CAPTURE_CONTROL_ADDR 12'h010
`define EVENT_STATUS_ADDR 12'h014
`define EVENT_MASK_ADDR 12'h018

// cycle state status fields (bit 0 is the lsb of the byte)
`define CSS_COMPLEMENT_BIT 6
`define CSS_MAJOR_MSB 5
`define CSS_MAJOR_LSB 2
`define CSS_MINOR_MSB 1
`define CSS_MINOR_LSB 0

// next major cycle codes
`define MAJOR_OPCODE 4'h0
`define MAJOR_QUALIFIER 4'h1
`define MAJOR_FIRST_HIGH_OR_INDEX 4'h2
`define MAJOR_FIRST_LOW 4'h3
`define MAJOR_SECOND_HIGH_OR_INDEX 4'h4
`define MAJOR_SECOND_LOW 4'h5
`define MAJOR_OPERAND_TWO_FETCH 4'h8
`define MAJOR_OPERAND_ONE_FETCH 4'ha
`define MAJOR_THIRD_EXECUTE 4'hc

// last minor time codes
`define MINOR_A_CODE 2'h3
`define MINOR_B_CODE 2'h2
`define MINOR_D_CODE 2'h1
`define MINOR_C_CODE 2'h0

// storage check codes
`define STORE_NO_CHECK 2'h0
`define STORE_EXCEPTION 2'h1
`define STORE_ADDRESS_CHECK 2'h2
`define STORE_SAR_PARITY 2'h3

// control and event fields
`define CTRL_REARM_BIT 0
`define CTRL_ARMED_BIT 1
`define EVT_CAPTURED_BIT 0
`define EVT_OVERRUN_BIT 1
`define EVT_WIDTH 2

// reset values, and the failing address read when the address is unknown
`define EVENT_STATUS_RESET 2'h0
`define EVENT_MASK_RESET 2'h0
`define FAILING_ADDRESS_UNKNOWN 16'h0000

`endif

// ---- hdl/capture_hold_reg.v ----
// capture register that loads on a strobe and holds its value otherwise
`timescale 1ns/10ps
`default_nettype none

module capture_hold_reg #(
    parameter WIDTH = 8
) (
    input wire i_clk,
    input wire i_resetn,
    input wire i_load,
    input wire [WIDTH-1:0] i_data,
    output wire [WIDTH-1:0] o_data
);

    reg [WIDTH-1:0] hold_r; // frozen snapshot

    // load on strobe, hold otherwise
    always @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            hold_r <= {WIDTH{1'b0}};
        end else if (i_load) begin
            hold_r <= i_data;
        end
    end

    assign o_data = hold_r;

endmodule

`default_nettype wire

// ---- hdl/processor_error_status_capture.v ----
// processor error status capture with apb register access and interrupt
`timescale 1ns/10ps
`default_nettype none
`include "error_capture_regs.vh"

module processor_error_status_capture #(
    parameter ADDR_WIDTH = 16
) (
    input wire I_CORE_CLK,
    input wire I_RESETN,
    // apb slave
    input wire i_PSEL,
    input wire i_PENABLE,
    input wire i_PWRITE,
    input wire [11:0] i_PADDR,
    input wire [31:0] i_PWDATA,
    output wire o_PREADY,
    output wire o_PSLVERR,
    output wire [31:0] o_PRDATA,
    // logout trigger from the error detection logic
    input wire i_ERROR_LOGOUT,
    // live cycle state
    input wire i_COMPLEMENT_LATCH,
    input wire i_OPCODE_CYCLE,
    input wire i_QUALIFIER_CYCLE,
    input wire i_FIRST_HIGH_OR_INDEX_CYCLE,
    input wire i_FIRST_LOW_CYCLE,
    input wire i_SECOND_HIGH_OR_INDEX_CYCLE,
    input wire i_SECOND_LOW_CYCLE,
    input wire i_OPERAND_TWO_FETCH_CYCLE,
    input wire i_OPERAND_ONE_FETCH_CYCLE,
    input wire i_THIRD_EXECUTE_CYCLE,
    input wire i_MINOR_TIME_A,
    input wire i_MINOR_TIME_B,
    input wire i_MINOR_TIME_C,
    input wire i_MINOR_TIME_D,
    // live processor checks and states
    input wire i_INVALID_INSTRUCTION,
    input wire i_CONTROL_GATE_CHECK,
    input wire i_LOCAL_STORE_GATE_CHECK,
    input wire i_MAIN_STORE_GATE_CHECK,
    input wire i_FIRST_CYCLE,
    input wire i_RECOMPLEMENT_CYCLE,
    input wire i_PROCESSOR_ADDRESS_CHECK,
    input wire i_CARRY_TRIGGER,
    // live storage checks
    input wire i_STORAGE_EXCEPTION,
    input wire i_STORAGE_ADDRESS_CHECK,
    input wire i_STORAGE_ADDRESS_REGISTER_PARITY,
    // live real storage address
    input wire i_STORAGE_ADDRESSING,
    input wire i_ADDRESS_KNOWN,
    input wire [ADDR_WIDTH-1:0] i_REAL_ADDRESS,
    // interrupt and capture state
    output wire o_IRQ,
    output wire o_CAPTURE_ARMED
);

    // apb phase decode
    wire setup_phase; // first cycle of a transfer
    wire access_phase; // completing cycle of a transfer
    wire wr_en; // write takes effect
    wire mapped; // address hits a register
    // capture control
    reg armed_r; // capture armed, no snapshot held
    reg armed_nxt; // next armed state
    wire capture; // snapshot strobe this cycle
    wire rearm_wr; // software re-arm write
    // event flags and mask
    reg [`EVT_WIDTH-1:0] evt_status_r; // sticky events
    reg [`EVT_WIDTH-1:0] evt_status_nxt; // next sticky events
    reg [`EVT_WIDTH-1:0] evt_mask_r; // interrupt enables
    wire [`EVT_WIDTH-1:0] evt_set; // events this cycle
    wire [`EVT_WIDTH-1:0] evt_clr; // write-one-to-clear bits
    // live encoded status bytes
    reg [3:0] major_code; // encoded next major cycle
    reg [1:0] minor_code; // encoded last minor time
    reg [1:0] store_code; // encoded storage check
    wire [7:0] cycle_state_live; // byte 0 image
    wire [7:0] proc_check_live; // byte 2 image
    wire [7:0] store_check_live; // byte 3 image
    wire [ADDR_WIDTH-1:0] fail_addr_live; // failing address image
    // frozen snapshots
    wire [7:0] cycle_state_q; // held byte 0
    wire [7:0] proc_check_q; // held byte 2
    wire [7:0] store_check_q; // held byte 3
    wire [ADDR_WIDTH-1:0] fail_addr_q; // held failing address
    // read path
    reg [31:0] rdata_r; // read data register
    reg [31:0] rdata_nxt; // next read data
    reg slverr_r; // error answer register
    reg slverr_nxt; // next error answer

    assign setup_phase = i_PSEL & ~i_PENABLE;
    assign access_phase = i_PSEL & i_PENABLE;
    assign wr_en = access_phase & i_PWRITE;

    // only the seven word registers respond; byte 1 has no address
    assign mapped = (i_PADDR == `CYCLE_STATE_STATUS_ADDR) |
                    (i_PADDR == `PROCESSOR_CHECK_STATUS_ADDR) |
                    (i_PADDR == `STORAGE_CHECK_STATUS_ADDR) |
                    (i_PADDR == `FAILING_REAL_ADDRESS_ADDR) |
                    (i_PADDR == `CAPTURE_CONTROL_ADDR) |
                    (i_PADDR == `EVENT_STATUS_ADDR) |
                    (i_PADDR == `EVENT_MASK_ADDR);

    // next major cycle encoder, first active cycle wins
    always @* begin
        if (i_OPCODE_CYCLE) begin
            major_code = `MAJOR_OPCODE;
        end else if (i_QUALIFIER_CYCLE) begin
            major_code = `MAJOR_QUALIFIER;
        end else if (i_FIRST_HIGH_OR_INDEX_CYCLE) begin
            major_code = `MAJOR_FIRST_HIGH_OR_INDEX;
        end else if (i_FIRST_LOW_CYCLE) begin
            major_code = `MAJOR_FIRST_LOW;
        end else if (i_SECOND_HIGH_OR_INDEX_CYCLE) begin
            major_code = `MAJOR_SECOND_HIGH_OR_INDEX;
        end else if (i_SECOND_LOW_CYCLE) begin
            major_code = `MAJOR_SECOND_LOW;
        end else if (i_OPERAND_TWO_FETCH_CYCLE) begin
            major_code = `MAJOR_OPERAND_TWO_FETCH;
        end else if (i_OPERAND_ONE_FETCH_CYCLE) begin
            major_code = `MAJOR_OPERAND_ONE_FETCH;
        end else if (i_THIRD_EXECUTE_CYCLE) begin
            major_code = `MAJOR_THIRD_EXECUTE;
        end else begin
            major_code = `MAJOR_OPCODE; // idle reads as opcode
        end
    end

    // last minor time encoder
    always @* begin
        if (i_MINOR_TIME_A) begin
            minor_code = `MINOR_A_CODE;
        end else if (i_MINOR_TIME_B) begin
            minor_code = `MINOR_B_CODE;
        end else if (i_MINOR_TIME_D) begin
            minor_code = `MINOR_D_CODE;
        end else if (i_MINOR_TIME_C) begin
            minor_code = `MINOR_C_CODE;
        end else begin
            minor_code = `MINOR_C_CODE; // minor c or none
        end
    end

    // storage check encoder, parity outranks address, then exception
    always @* begin
        if (i_STORAGE_ADDRESS_REGISTER_PARITY) begin
            store_code = `STORE_SAR_PARITY;
        end else if (i_STORAGE_ADDRESS_CHECK) begin
            store_code = `STORE_ADDRESS_CHECK;
        end else if (i_STORAGE_EXCEPTION) begin
            store_code = `STORE_EXCEPTION;
        end else begin
            store_code = `STORE_NO_CHECK;
        end
    end

    // byte 0: msb unused, complement, major, minor
    assign cycle_state_live = {1'b0, i_COMPLEMENT_LATCH, major_code,
                               minor_code};

    // byte 2, bit 0 of the byte sits in the msb
    assign proc_check_live = {i_INVALID_INSTRUCTION,
                              i_CONTROL_GATE_CHECK,
                              i_LOCAL_STORE_GATE_CHECK,
                              i_MAIN_STORE_GATE_CHECK,
                              i_FIRST_CYCLE,
                              i_RECOMPLEMENT_CYCLE,
                              i_PROCESSOR_ADDRESS_CHECK,
                              i_CARRY_TRIGGER};

    // byte 3: upper six bits unused
    assign store_check_live = {6'h00, store_code};

    // address zero unless storage was addressed at a known location
    assign fail_addr_live = (i_STORAGE_ADDRESSING & i_ADDRESS_KNOWN) ?
                            i_REAL_ADDRESS :
                            `FAILING_ADDRESS_UNKNOWN;

    // snapshot only while armed, so the first error wins
    assign capture = i_ERROR_LOGOUT & armed_r;
    assign rearm_wr = wr_en & (i_PADDR == `CAPTURE_CONTROL_ADDR) &
                      i_PWDATA[`CTRL_REARM_BIT];

    // armed state: capture disarms, software re-arm arms again
    always @* begin
        armed_nxt = armed_r;
        if (capture) begin
            armed_nxt = 1'b0;
        end else if (rearm_wr) begin
            armed_nxt = 1'b1;
        end
    end

    // armed register, armed out of reset
    always @(posedge I_CORE_CLK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            armed_r <= 1'b1;
        end else begin
            armed_r <= armed_nxt;
        end
    end

    // snapshot registers, one per status byte and one for the address
    capture_hold_reg #(
        .WIDTH(8)
    ) u_cycle_state (
        .i_clk(I_CORE_CLK),
        .i_resetn(I_RESETN),
        .i_load(capture),
        .i_data(cycle_state_live),
        .o_data(cycle_state_q)
    );
    capture_hold_reg #(
        .WIDTH(8)
    ) u_proc_check (
        .i_clk(I_CORE_CLK),
        .i_resetn(I_RESETN),
        .i_load(capture),
        .i_data(proc_check_live),
        .o_data(proc_check_q)
    );
    capture_hold_reg #(
        .WIDTH(8)
    ) u_store_check (
        .i_clk(I_CORE_CLK),
        .i_resetn(I_RESETN),
        .i_load(capture),
        .i_data(store_check_live),
        .o_data(store_check_q)
    );
    capture_hold_reg #(
        .WIDTH(ADDR_WIDTH)
    ) u_fail_addr (
        .i_clk(I_CORE_CLK),
        .i_resetn(I_RESETN),
        .i_load(capture),
        .i_data(fail_addr_live),
        .o_data(fail_addr_q)
    );

    // events: captured, and error seen while frozen
    assign evt_set = {i_ERROR_LOGOUT & ~armed_r, capture};
    assign evt_clr = (wr_en & (i_PADDR == `EVENT_STATUS_ADDR)) ?
                     i_PWDATA[`EVT_WIDTH-1:0] : {`EVT_WIDTH{1'b0}};

    // sticky flags, a new event beats a clear in the same cycle
    always @* begin
        evt_status_nxt = (evt_status_r & ~evt_clr) | evt_set;
    end

    // event status and mask registers
    always @(posedge I_CORE_CLK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            evt_status_r <= `EVENT_STATUS_RESET;
            evt_mask_r <= `EVENT_MASK_RESET;
        end else begin
            evt_status_r <= evt_status_nxt;
            if (wr_en & (i_PADDR == `EVENT_MASK_ADDR)) begin
                evt_mask_r <= i_PWDATA[`EVT_WIDTH-1:0];
            end
        end
    end

    // read mux, sampled in the setup cycle
    always @* begin
        rdata_nxt = rdata_r;
        slverr_nxt = slverr_r;
        if (setup_phase) begin
            slverr_nxt = ~mapped; // unmapped answers with an error
            case (i_PADDR)
                `CYCLE_STATE_STATUS_ADDR: begin
                    rdata_nxt = {24'h000000, cycle_state_q};
                end
                `PROCESSOR_CHECK_STATUS_ADDR: begin
                    rdata_nxt = {24'h000000, proc_check_q};
                end
                `STORAGE_CHECK_STATUS_ADDR: begin
                    rdata_nxt = {24'h000000, store_check_q};
                end
                `FAILING_REAL_ADDRESS_ADDR: begin
                    rdata_nxt = {{(32-ADDR_WIDTH){1'b0}}, fail_addr_q};
                end
                `CAPTURE_CONTROL_ADDR: begin
                    rdata_nxt = {30'h0, armed_r, 1'b0};
                end
                `EVENT_STATUS_ADDR: begin
                    rdata_nxt = {30'h0, evt_status_r};
                end
                `EVENT_MASK_ADDR: begin
                    rdata_nxt = {30'h0, evt_mask_r};
                end
                default: begin
                    rdata_nxt = 32'h00000000; // byte 1 and holes
                end
            endcase
        end
    end

    // read data and error registers
    always @(posedge I_CORE_CLK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            rdata_r <= 32'h00000000;
            slverr_r <= 1'b0;
        end else begin
            rdata_r <= rdata_nxt;
            slverr_r <= slverr_nxt;
        end
    end

    // zero wait state slave
    assign o_PREADY = 1'b1;
    assign o_PSLVERR = slverr_r & access_phase;
    assign o_PRDATA = rdata_r;

    // level interrupt from unmasked sticky events
    assign o_IRQ = |(evt_status_r & evt_mask_r);
    assign o_CAPTURE_ARMED = armed_r;

endmodule

`default_nettype wire

// ---- sim/error_capture_properties.sv ----
// concurrent checks on the error status capture ports
`timescale 1ns/10ps
`default_nettype none
`include "error_capture_regs.vh"
module error_capture_properties (
    input wire logic I_CORE_CLK,
    input wire logic I_RESETN,
    input wire logic i_PSEL,
    input wire logic i_PENABLE,
    input wire logic i_PWRITE,
    input wire logic [11:0] i_PADDR,
    input wire logic [31:0] i_PWDATA,
    input wire logic o_PSLVERR,
    input wire logic [31:0] o_PRDATA,
    input wire logic i_ERROR_LOGOUT,
    input wire logic i_COMPLEMENT_LATCH,
    input wire logic i_CARRY_TRIGGER,
    input wire logic i_STORAGE_ADDRESSING,
    input wire logic i_ADDRESS_KNOWN,
    input wire logic o_CAPTURE_ARMED
);
    logic cmp_r; // complement latch seen at the last capture
    logic carry_r; // carry trigger seen at the last capture
    logic known_r; // failing address was valid at the last capture
    wire setup = i_PSEL && !i_PENABLE && !i_PWRITE; // read setup cycle
    wire access = i_PSEL && i_PENABLE; // apb access phase
    wire rearm = access && i_PWRITE && i_PWDATA[0]
        && i_PADDR == `CAPTURE_CONTROL_ADDR;
    wire mapped = i_PADDR inside {`CYCLE_STATE_STATUS_ADDR,
        `PROCESSOR_CHECK_STATUS_ADDR, `STORAGE_CHECK_STATUS_ADDR,
        `FAILING_REAL_ADDRESS_ADDR, `CAPTURE_CONTROL_ADDR,
        `EVENT_STATUS_ADDR, `EVENT_MASK_ADDR};
    // mirror of what a capture should have frozen
    always @(posedge I_CORE_CLK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            cmp_r <= 1'b0;
            carry_r <= 1'b0;
            known_r <= 1'b0;
        end else if (i_ERROR_LOGOUT && o_CAPTURE_ARMED) begin
            cmp_r <= i_COMPLEMENT_LATCH;
            carry_r <= i_CARRY_TRIGGER;
            known_r <= i_STORAGE_ADDRESSING && i_ADDRESS_KNOWN;
        end
    end
    default clocking @(posedge I_CORE_CLK); endclocking
    default disable iff (!I_RESETN);
    chk_capture_disarms: assert property (
        i_ERROR_LOGOUT && o_CAPTURE_ARMED |=> !o_CAPTURE_ARMED)
        else $error("armed stayed high after a capture");
    chk_stays_frozen: assert property (
        !o_CAPTURE_ARMED && !rearm |=> !o_CAPTURE_ARMED)
        else $error("capture re-armed without a write");
    chk_rearm_arms: assert property (
        rearm && !i_ERROR_LOGOUT |=> o_CAPTURE_ARMED)
        else $error("re-arm write did not arm");
    chk_cycle_byte: assert property (
        setup && i_PADDR == `CYCLE_STATE_STATUS_ADDR
        |=> o_PRDATA[31:7] == 25'h0 && o_PRDATA[6] == $past(cmp_r))
        else $error("cycle state byte wrong");
    chk_carry_byte: assert property (
        setup && i_PADDR == `PROCESSOR_CHECK_STATUS_ADDR
        |=> o_PRDATA[31:8] == 24'h0 && o_PRDATA[0] == $past(carry_r))
        else $error("processor check byte wrong");
    chk_storage_unused: assert property (
        setup && i_PADDR == `STORAGE_CHECK_STATUS_ADDR
        |=> o_PRDATA[31:2] == 30'h0)
        else $error("storage check unused bits set");
    chk_address_zero: assert property (
        setup && i_PADDR == `FAILING_REAL_ADDRESS_ADDR && !known_r
        |=> o_PRDATA == 32'h0)
        else $error("unknown failing address not zero");
    chk_unmapped_err: assert property (
        access && !mapped |-> o_PSLVERR)
        else $error("unmapped access not refused");
    chk_mapped_ok: assert property (
        access && mapped |-> !o_PSLVERR)
        else $error("mapped access refused");
endmodule
`default_nettype wire

// ---- sim/testbench.sv ----
// self-checking bench for the processor error status capture
`timescale 1ns/10ps
`default_nettype none
`include "error_capture_regs.vh"
module testbench;
    logic clk = 1'b0; // core clock
    logic rstn = 1'b0; // active low reset
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic err = 1'b0; // logout trigger
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] rd; // read data of the last transfer
    logic slv; // error flag of the last transfer
    logic [43:0] live = 44'h0; // packed live processor state
    wire pready;
    wire pslverr;
    wire irq;
    wire armed;
    wire [31:0] prdata;
    // one-hot decode of the major and minor indices
    wire [8:0] maj = (live[39:36] < 4'h9) ? 9'h001 << live[39:36] : 9'h0;
    wire [3:0] mnr = (live[35:32] < 4'h4) ? 4'h1 << live[35:32] : 4'h0;
    int err_count = 0;
    int n_tests = 0;
    // cmp, major, minor (a b c d), checks, storage, flags, address
    logic [43:0] row_in [10] = '{44'h1_0_0_80_1_3_1234,
        44'h0_1_1_40_2_1_ffff, 44'h1_2_2_20_4_2_5a5a,
        44'h0_3_3_10_7_3_0001, 44'h0_4_0_08_3_3_8000,
        44'h1_5_1_04_0_0_1111, 44'h0_6_2_02_0_3_00ff,
        44'h0_7_3_01_0_3_abcd, 44'h1_8_4_ff_0_3_fffe,
        44'h0_9_4_00_0_3_4321};
    // expected cycle, processor, storage bytes and failing address
    logic [39:0] row_exp [10] = '{40'h43_80_01_1234, 40'h06_40_02_0000,
        40'h48_20_03_0000, 40'h0d_10_03_0001, 40'h13_08_02_8000,
        40'h56_04_00_0000, 40'h20_02_00_00ff, 40'h29_01_00_abcd,
        40'h70_ff_00_fffe, 40'h00_00_00_4321};
    logic [11:0] snap_addr [4] = '{`CYCLE_STATE_STATUS_ADDR,
        `PROCESSOR_CHECK_STATUS_ADDR, `STORAGE_CHECK_STATUS_ADDR,
        `FAILING_REAL_ADDRESS_ADDR};
    processor_error_status_capture i_dut (
        .I_CORE_CLK(clk), .I_RESETN(rstn),
        .i_PSEL(psel), .i_PENABLE(penable), .i_PWRITE(pwrite),
        .i_PADDR(paddr), .i_PWDATA(pwdata), .o_PREADY(pready),
        .o_PSLVERR(pslverr), .o_PRDATA(prdata), .i_ERROR_LOGOUT(err),
        .i_COMPLEMENT_LATCH(live[40]),
        .i_OPCODE_CYCLE(maj[0]), .i_QUALIFIER_CYCLE(maj[1]),
        .i_FIRST_HIGH_OR_INDEX_CYCLE(maj[2]), .i_FIRST_LOW_CYCLE(maj[3]),
        .i_SECOND_HIGH_OR_INDEX_CYCLE(maj[4]), .i_SECOND_LOW_CYCLE(maj[5]),
        .i_OPERAND_TWO_FETCH_CYCLE(maj[6]),
        .i_OPERAND_ONE_FETCH_CYCLE(maj[7]), .i_THIRD_EXECUTE_CYCLE(maj[8]),
        .i_MINOR_TIME_A(mnr[0]), .i_MINOR_TIME_B(mnr[1]),
        .i_MINOR_TIME_C(mnr[2]), .i_MINOR_TIME_D(mnr[3]),
        .i_INVALID_INSTRUCTION(live[31]), .i_CONTROL_GATE_CHECK(live[30]),
        .i_LOCAL_STORE_GATE_CHECK(live[29]),
        .i_MAIN_STORE_GATE_CHECK(live[28]), .i_FIRST_CYCLE(live[27]),
        .i_RECOMPLEMENT_CYCLE(live[26]),
        .i_PROCESSOR_ADDRESS_CHECK(live[25]), .i_CARRY_TRIGGER(live[24]),
        .i_STORAGE_EXCEPTION(live[20]), .i_STORAGE_ADDRESS_CHECK(live[21]),
        .i_STORAGE_ADDRESS_REGISTER_PARITY(live[22]),
        .i_STORAGE_ADDRESSING(live[17]), .i_ADDRESS_KNOWN(live[16]),
        .i_REAL_ADDRESS(live[15:0]), .o_IRQ(irq), .o_CAPTURE_ARMED(armed)
    );
    // free-running core clock
    initial begin
        forever #4 clk = ~clk;
    end
    // compare one value and count it
    task automatic check(input string name, input logic [31:0] seen, exp);
        n_tests++;
        if (seen !== exp) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask
    // one apb transfer, entered just after a rising edge
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        // the wait ends once ready is seen; only the watchdog ends a wait for ready that never comes
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rd = prdata;
        slv = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask
    // read a register and compare data and error flag
    task automatic rdchk(input string name, input logic [11:0] a,
                         input logic [31:0] exp, input logic e);
        apb(1'b0, a, 32'h0);
        check(name, rd, exp);
        check("pslverr", {31'h0, slv}, {31'h0, e});
    endtask
    // read back the four snapshot registers against one row
    task automatic snap(input logic [39:0] e);
        apb(1'b0, `CYCLE_STATE_STATUS_ADDR, 32'h0);
        check("cycle byte", rd, {24'h0, e[39:32]});
        check("complement", rd[7:6], e[39:38]);
        apb(1'b0, `PROCESSOR_CHECK_STATUS_ADDR, 32'h0);
        check("check byte", rd, {24'h0, e[31:24]});
        check("cycle flags", rd[3:0], e[27:24]);
        apb(1'b0, `STORAGE_CHECK_STATUS_ADDR, 32'h0);
        check("storage byte", rd, {24'h0, e[23:16]});
        apb(1'b0, `FAILING_REAL_ADDRESS_ADDR, 32'h0);
        check("address", rd, {16'h0, e[15:0]});
        check("pslverr", {31'h0, slv}, 32'h0);
        // a row with a parity-damaged address leaves 7777 in rd after its checks
        if (e[17:16] == `STORE_SAR_PARITY) begin
            rd = 32'h7777;
        end
    endtask
    // one-cycle logout pulse, then scramble the live state
    task automatic logout();
        err <= 1'b1;
        @(posedge clk);
        err <= 1'b0;
        live <= ~live;
        @(posedge clk);
    endtask
    // verdict and end of run
    task automatic results();
        if (err_count == 0 && n_tests > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // watchdog against a hung handshake
    initial begin
        repeat (5000) @(posedge clk);
        err_count++;
        results();
    end
    // main sequence
    initial begin
        repeat (8) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        for (int k = 0; k < 4; k++) begin
            rdchk("snapshot", snap_addr[k], 32'h0, 1'b0);
        end
        rdchk("control", `CAPTURE_CONTROL_ADDR, 32'h2, 1'b0);
        check("reset irq", {31'h0, irq}, 32'h0);
        apb(1'b1, `EVENT_MASK_ADDR, 32'h3);
        for (int i = 0; i < 10; i++) begin
            live <= row_in[i];
            @(posedge clk);
            logout();
            check("armed", {31'h0, armed}, 32'h0);
            check("irq", {31'h0, irq}, 32'h1);
            snap(row_exp[i]);
            apb(1'b1, `EVENT_STATUS_ADDR, 32'h1);
            apb(1'b1, `CAPTURE_CONTROL_ADDR, 32'h1);
        end
        // second error while frozen keeps the first snapshot
        live <= row_in[0];
        @(posedge clk);
        logout();
        logout();
        rdchk("frozen", `CYCLE_STATE_STATUS_ADDR, 32'h43, 1'b0);
        rdchk("events", `EVENT_STATUS_ADDR, 32'h3, 1'b0);
        rdchk("control", `CAPTURE_CONTROL_ADDR, 32'h0, 1'b0);
        // read-only write ignored, unmapped place refused
        apb(1'b1, `CYCLE_STATE_STATUS_ADDR, 32'hffff_ffff);
        rdchk("ro", `CYCLE_STATE_STATUS_ADDR, 32'h43, 1'b0);
        rdchk("unmapped", 12'h01c, 32'h0, 1'b1);
        // masking and clearing drop the interrupt
        apb(1'b1, `EVENT_MASK_ADDR, 32'h0);
        check("masked irq", {31'h0, irq}, 32'h0);
        apb(1'b1, `EVENT_MASK_ADDR, 32'h3);
        check("unmasked irq", {31'h0, irq}, 32'h1);
        apb(1'b1, `EVENT_STATUS_ADDR, 32'h3);
        check("cleared irq", {31'h0, irq}, 32'h0);
        // reset in mid-run clears the snapshot and re-arms
        rstn <= 1'b0;
        @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        rdchk("reset", `CYCLE_STATE_STATUS_ADDR, 32'h0, 1'b0);
        rdchk("control", `CAPTURE_CONTROL_ADDR, 32'h2, 1'b0);
        results();
    end
endmodule
bind processor_error_status_capture error_capture_properties i_chk (
    .I_CORE_CLK(I_CORE_CLK), .I_RESETN(I_RESETN), .i_PSEL(i_PSEL),
    .i_PENABLE(i_PENABLE), .i_PWRITE(i_PWRITE), .i_PADDR(i_PADDR),
    .i_PWDATA(i_PWDATA), .o_PSLVERR(o_PSLVERR), .o_PRDATA(o_PRDATA),
    .i_ERROR_LOGOUT(i_ERROR_LOGOUT), .i_COMPLEMENT_LATCH(i_COMPLEMENT_LATCH),
    .i_CARRY_TRIGGER(i_CARRY_TRIGGER),
    .i_STORAGE_ADDRESSING(i_STORAGE_ADDRESSING),
    .i_ADDRESS_KNOWN(i_ADDRESS_KNOWN), .o_CAPTURE_ARMED(o_CAPTURE_ARMED)
);
`default_nettype wire
